// File: hw/pio_port.sv
// Sixteen-bit parallel input/output port with latched inputs and handshakes.
//
// How it works
// - With loopback on, the output word reads back from the input register unchanged on connected lines; unconnected lines read zero.
// - Input lines marked unconnected are clamped so they read as zero.
// - Latched bits set on a falling edge and hold until software clears them.
// - Direct bits read the present synchronised line level.
// - Per-bit interrupt enables; latched pending bits show which lines interrupted.
// - Lines 15 to 12 can set on either edge and interrupt.
// - All direct, top four enabled, any change interrupts, is a valid setup.
// - Each output byte can be loaded alone with its own ready pulse.
// - Output lines and handshakes match the input side of a twin port.
// - Accepted, high ready and low ready are one microsecond pulses, polarity selectable.
// - Status at offset 0, input at 2, output at 4.
// - Input and output vectors differ only in vector bit 2.
// - Lines 15 to 12 select falling, rising or either edge; falling by default.
//
// The address map and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
module pio_port
	import pio_pkg::*;
#(
	parameter int PULSE_W = PULSE_CYC
) (
	input wire logic ref_clk, // System clock, 50 MHz.
	input wire logic resetn, // Asynchronous reset, active low.
	input wire logic [ADDR_W-1:0] addr, // Register byte offset.
	input wire logic [DATA_W-1:0] wdata, // Write data.
	input wire logic wr, // Write strobe.
	input wire logic rd, // Read strobe.
	output logic [DATA_W-1:0] rdata, // Read data, valid the cycle after rd.
	input wire logic [DATA_W-1:0] din, // External input lines.
	output logic [DATA_W-1:0] dout, // External output lines.
	output logic data_accepted, // Accept pulse to the source.
	output logic hi_ready, // Upper byte ready pulse.
	output logic lo_ready, // Lower byte ready pulse.
	output logic irq, // Level interrupt request.
	output logic [8:0] irq_vector // Vector of the pending request.
);
	// Offsets 0, 2 and 4 hold status, input and output; the rest keep per-line
	// mode, enables, edge choice, polarity, vector base and the connected-line mask,
	// so software sets up what a board would otherwise fix by hand.
	logic [15:0] mode_r;
	logic [15:0] ien_r;
	logic [15:0] ipend_r;
	logic [15:0] latch_r;
	logic [7:0] edge_r;
	logic [3:0] ctrl_r;
	logic [5:0] vec_r;
	logic [15:0] conn_r;
	logic in_ie_r;
	logic out_ie_r;
	logic out_done_r;
	logic [15:0] raw;
	logic [15:0] cur;
	logic [15:0] prev_r;
	logic [15:0] hit;
	logic [15:0] in_val;
	logic acc_fire;
	logic hi_fire;
	logic lo_fire;
	logic acc_line;
	logic hi_line;
	logic lo_line;
	logic hi_busy;
	logic lo_busy;
	logic busy_prev_r;
	logic in_req;
	logic out_req;
	logic [15:0] in_clr;
	logic [15:0] pend_clr;
	logic [15:0] status_val;
	logic word_wr;
	logic ready_busy;
	logic in_any;
	logic out_sel;

	// Edge test for one line under a selection code.
	function automatic logic edge_hit(input logic p, input logic c, input logic [1:0] sel);
		logic r;
		r = 1'b0;
		case (sel)
			EDGE_FALL: r = p & ~c;
			EDGE_RISE: r = ~p & c;
			default: r = p ^ c;
		endcase
		return r;
	endfunction

	// Write strobe aimed at one offset.
	function automatic logic wr_at(input logic [4:0] a, input logic w, input logic [4:0] off);
		return w && a == off;
	endfunction

	// Loopback takes the output word in place of the pins; open lines are clamped low.
	assign raw = (ctrl_r[CT_LOOP] ? dout : din) & conn_r;

	line_sync #(.W(DATA_W)) u_sync (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.d(raw),
		.q(cur)
	);

	// Keep the previous synchronised level for edge detection.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			prev_r <= '0;
		end else begin
			prev_r <= cur;
		end
	end

	// Lines 11..0 set on falling edges; lines 15..12 on their chosen edge.
	always_comb begin
		hit = prev_r & ~cur;
		for (int i = 0; i < EDGE_LINES; i++) begin
			hit[EDGE_BASE + i] = edge_hit(prev_r[EDGE_BASE + i], cur[EDGE_BASE + i],
				edge_r[2*i +: 2]);
		end
	end

	// Ones written to the input register clear latch and pending bits alike; the
	// pending register can also be cleared alone without touching the latches.
	assign in_clr = wr_at(addr, wr, OFF_INPUT) ? wdata : 16'h0000;
	assign pend_clr = in_clr | (wr_at(addr, wr, OFF_IPEND) ? wdata : 16'h0000);

	// Latched bits hold until cleared; a new edge wins over a clear in the same cycle.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			latch_r <= '0;
		end else begin
			latch_r <= (latch_r & ~in_clr)
				| (hit & mode_r);
		end
	end

	// Pending interrupt bits catch every edge that hit detects, in direct mode too, so that
	// a direct line can still interrupt on change.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			ipend_r <= '0;
		end else begin
			ipend_r <= (ipend_r & ~pend_clr)
				| hit;
		end
	end

	// Direct bits show the line, latched bits the latch; loopback always reads direct
	// so the written word comes back unchanged on connected lines.
	assign in_val = ctrl_r[CT_LOOP] ? cur : ((mode_r & latch_r) | (~mode_r & cur));

	// Configuration registers written by software.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			mode_r <= MODE_RST;
			ien_r <= IEN_RST;
			edge_r <= EDGE_RST;
			ctrl_r <= CTRL_RST;
			vec_r <= VEC_RST;
			conn_r <= CONN_RST;
		end else if (wr) begin
			case (addr)
				OFF_MODE: mode_r <= wdata;
				OFF_IEN: ien_r <= wdata;
				OFF_EDGE: edge_r <= wdata[7:0];
				OFF_CTRL: ctrl_r <= wdata[3:0];
				OFF_VEC: vec_r <= wdata[8:3];
				OFF_CONN: conn_r <= wdata;
				default: ;
			endcase
		end
	end

	// Interrupt enables of the status register.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			in_ie_r <= 1'b0;
			out_ie_r <= 1'b0;
		end else if (wr_at(addr, wr, OFF_STATUS)) begin
			in_ie_r <= wdata[ST_IN_IE];
			out_ie_r <= wdata[ST_OUT_IE];
		end
	end

	// Output word, whole or one byte at a time.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			dout <= '0;
		end else if (wr) begin
			case (addr)
				OFF_OUTPUT: dout <= wdata;
				OFF_OUT_HI: dout[15:8] <= wdata[15:8];
				OFF_OUT_LO: dout[7:0] <= wdata[7:0];
				default: ;
			endcase
		end
	end

	// Ready pulses start with the write, so the byte reaches the lines
	// on the same clock edge that starts the pulse.
	assign word_wr = wr_at(addr, wr, OFF_OUTPUT);
	assign hi_fire = word_wr | wr_at(addr, wr, OFF_OUT_HI);
	assign lo_fire = word_wr | wr_at(addr, wr, OFF_OUT_LO);
	// A read of the input register acknowledges the source.
	assign acc_fire = rd && addr == OFF_INPUT;

	// Each handshake line has its own generator, so one pulse never cuts another short.
	hs_pulse #(.WIDTH(PULSE_W)) u_acc (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.fire(acc_fire),
		.pol_pos(ctrl_r[CT_POL_ACC]),
		.line(acc_line),
		.busy()
	);

	hs_pulse #(.WIDTH(PULSE_W)) u_hi (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.fire(hi_fire),
		.pol_pos(ctrl_r[CT_POL_HI]),
		.line(hi_line),
		.busy(hi_busy)
	);

	hs_pulse #(.WIDTH(PULSE_W)) u_lo (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.fire(lo_fire),
		.pol_pos(ctrl_r[CT_POL_LO]),
		.line(lo_line),
		.busy(lo_busy)
	);

	// Handshake lines come straight from the output flops of the pulse generators.
	assign data_accepted = acc_line;
	assign hi_ready = hi_line;
	assign lo_ready = lo_line;

	// Either ready pulse still running holds off output done, so a byte pulse
	// that outlasts the other does not report completion early.
	assign ready_busy = hi_busy | lo_busy;

	// Output done is set when the last ready pulse ends; the set wins over a clear.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			busy_prev_r <= 1'b0;
			out_done_r <= 1'b0;
		end else begin
			busy_prev_r <= ready_busy;
			out_done_r <= (out_done_r
				& ~(wr_at(addr, wr, OFF_STATUS) & wdata[ST_OUT_DONE]))
				| (busy_prev_r & ~ready_busy);
		end
	end

	// An input request needs the status enable and at least one enabled pending line.
	assign in_any = |(ipend_r & ien_r);
	assign in_req = in_ie_r & in_any;
	assign out_req = out_ie_r & out_done_r;
	// The output vector is chosen only when no input request is waiting.
	assign out_sel = ~in_req & out_req;

	// Input takes priority; the two vectors differ only in bit 2.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			irq <= 1'b0;
			irq_vector <= {VEC_RST, 3'h0};
		end else begin
			irq <= in_req | out_req;
			irq_vector <= {vec_r, out_sel, 2'h0};
		end
	end

	// Status word as software sees it; bits without a meaning read as zero.
	always_comb begin
		status_val = 16'h0000;
		status_val[ST_IN_REQ] = in_any;
		status_val[ST_IN_IE] = in_ie_r;
		status_val[ST_OUT_DONE] = out_done_r;
		status_val[ST_OUT_IE] = out_ie_r;
	end

	// Read data stand in the cycle after the strobe; unmapped offsets read zero.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rdata <= '0;
		end else if (rd) begin
			case (addr)
				OFF_STATUS: rdata <= status_val;
				OFF_INPUT: rdata <= in_val;
				OFF_OUTPUT: rdata <= dout;
				OFF_MODE: rdata <= mode_r;
				OFF_IEN: rdata <= ien_r;
				OFF_IPEND: rdata <= ipend_r;
				OFF_EDGE: rdata <= {8'h00, edge_r};
				OFF_CTRL: rdata <= {12'h000, ctrl_r};
				OFF_VEC: rdata <= {7'h00, vec_r, 3'h0};
				OFF_OUT_HI: rdata <= {dout[15:8], 8'h00};
				OFF_OUT_LO: rdata <= {8'h00, dout[7:0]};
				OFF_CONN: rdata <= conn_r;
				default: rdata <= '0;
			endcase
		end
	end
endmodule // pio_port

// File: hw/pio_pkg.sv
// Shared constants for the parallel word input/output port.
package pio_pkg;
	localparam int DATA_W = 16;
	localparam int ADDR_W = 5;
	// Byte offsets of the registers.
	localparam logic [4:0] OFF_STATUS = 5'h00;
	localparam logic [4:0] OFF_INPUT = 5'h02;
	localparam logic [4:0] OFF_OUTPUT = 5'h04;
	localparam logic [4:0] OFF_MODE = 5'h06;
	localparam logic [4:0] OFF_IEN = 5'h08;
	localparam logic [4:0] OFF_IPEND = 5'h0A;
	localparam logic [4:0] OFF_EDGE = 5'h0C;
	localparam logic [4:0] OFF_CTRL = 5'h0E;
	localparam logic [4:0] OFF_VEC = 5'h10;
	localparam logic [4:0] OFF_OUT_HI = 5'h12;
	localparam logic [4:0] OFF_OUT_LO = 5'h14;
	localparam logic [4:0] OFF_CONN = 5'h16;
	// Status register fields.
	localparam int ST_IN_REQ = 15;
	localparam int ST_IN_IE = 14;
	localparam int ST_OUT_DONE = 7;
	localparam int ST_OUT_IE = 6;
	// Control register fields.
	localparam int CT_LOOP = 0;
	localparam int CT_POL_ACC = 1;
	localparam int CT_POL_HI = 2;
	localparam int CT_POL_LO = 3;
	// Edge selection codes for lines 15..12, two bits per line.
	localparam logic [1:0] EDGE_FALL = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_ANY = 2'h2;
	localparam int EDGE_LINES = 4;
	localparam int EDGE_BASE = 12;
	// Values after reset.
	localparam logic [15:0] MODE_RST = 16'h0000;
	localparam logic [15:0] IEN_RST = 16'h0000;
	localparam logic [7:0] EDGE_RST = 8'h00;
	localparam logic [3:0] CTRL_RST = 4'h0;
	localparam logic [5:0] VEC_RST = 6'h18;
	localparam logic [15:0] CONN_RST = 16'hFFFF;
	localparam int VEC_SEL_BIT = 2;
	// Handshake pulse width.
	localparam int CLK_MHZ = 50;
	localparam int PULSE_NS = 1000;
	localparam int PULSE_CYC = (PULSE_NS * CLK_MHZ + 999) / 1000;
endpackage

// File: hw/line_sync.sv
// Two-stage synchroniser for a group of input lines.
`timescale 1ns/1ps
module line_sync #(
	parameter int W = 16
) (
	input wire logic ref_clk, // System clock.
	input wire logic resetn, // Asynchronous reset, active low.
	input wire logic [W-1:0] d, // Raw lines.
	output logic [W-1:0] q // Synchronised lines.
);
	logic [W-1:0] meta_r;

	// The first stage feeds only the second stage.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			meta_r <= '0;
			q <= '0;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule // line_sync

// File: hw/hs_pulse.sv
// Fixed-width handshake pulse generator with selectable polarity.
`timescale 1ns/1ps
module hs_pulse
	import pio_pkg::*;
#(
	parameter int WIDTH = PULSE_CYC
) (
	input wire logic ref_clk, // System clock.
	input wire logic resetn, // Asynchronous reset, active low.
	input wire logic fire, // Start a pulse.
	input wire logic pol_pos, // One for a high-going pulse.
	output logic line, // Handshake line.
	output logic busy // High while the pulse runs.
);
	logic [15:0] cnt_r;

	// A retrigger while busy restarts the full width so no pulse is cut short.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			cnt_r <= '0;
			busy <= 1'b0;
		end else if (fire) begin
			cnt_r <= 16'(WIDTH - 1);
			busy <= 1'b1;
		end else if (cnt_r != 16'h0000) begin
			cnt_r <= cnt_r - 16'h0001;
		end else begin
			busy <= 1'b0;
		end
	end

	// The line idles at the inactive level of the chosen polarity.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			line <= 1'b1;
		end else begin
			line <= (fire | (busy & cnt_r != 16'h0000)) ? pol_pos : ~pol_pos;
		end
	end
endmodule // hs_pulse

// File: test/pio_checker.sv
// Concurrent checks on the parallel word port, bound to its top module.
`timescale 1ns/1ps
module pio_checker
	import pio_pkg::*;
#(
	parameter int PULSE_W = PULSE_CYC
) (
	input wire logic ref_clk, // Clock.
	input wire logic resetn, // Reset.
	input wire logic [ADDR_W-1:0] addr, // Offset.
	input wire logic [DATA_W-1:0] wdata, // Write data.
	input wire logic wr, // Write.
	input wire logic rd, // Read.
	input wire logic [DATA_W-1:0] rdata, // Read data.
	input wire logic [DATA_W-1:0] din, // Lines in.
	input wire logic [DATA_W-1:0] dout, // Lines out.
	input wire logic data_accepted, // Accept.
	input wire logic hi_ready, // High ready.
	input wire logic lo_ready, // Low ready.
	input wire logic irq, // Interrupt.
	input wire logic [8:0] irq_vector // Vector.
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	logic [3:0] pol_r;
	logic [3:0] pol_d_r;
	logic [7:0] acc_cnt_r;
	logic acc_on;
	// Polarity copy; the lagging stage keeps a polarity change from looking like a pulse.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			pol_r <= CTRL_RST;
			pol_d_r <= CTRL_RST;
		end else begin
			pol_r <= (wr && addr == OFF_CTRL) ? wdata[3:0] : pol_r;
			pol_d_r <= pol_r;
		end
	end
	assign acc_on = (data_accepted == pol_d_r[CT_POL_ACC]);
	// Active cycles of the accept line, restarted by each input read.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			acc_cnt_r <= 8'h00;
		end else if ((rd && addr == OFF_INPUT) || !acc_on) begin
			acc_cnt_r <= 8'h00;
		end else begin
			acc_cnt_r <= acc_cnt_r + 8'h01;
		end
	end
	out_word_a: assert property (wr && addr == OFF_OUTPUT |=> dout == $past(wdata))
		else $error("output word not loaded");
	hi_keeps_lo_a: assert property (wr && addr == OFF_OUT_HI |=> $stable(dout[7:0]))
		else $error("upper byte write changed lower byte");
	acc_start_a: assert property (rd && addr == OFF_INPUT && pol_r == pol_d_r |=> acc_on)
		else $error("no accept pulse after input read");
	acc_width_a: assert property ($fell(acc_on) && $stable(pol_d_r) |-> acc_cnt_r == PULSE_W)
		else $error("accept pulse width wrong");
	vec_low_a: assert property (irq |-> irq_vector[1:0] == 2'b00)
		else $error("vector low bits not zero");
	reset_clear_a: assert property ($rose(resetn) |-> dout == 16'h0000 && !irq)
		else $error("reset left output or interrupt set");
	irq_off_a: assert property (wr && addr == OFF_STATUS && wdata == 16'h0000 |=> ##1 !irq)
		else $error("interrupt stayed with enables off");
	rdata_hold_a: assert property (!rd |=> $stable(rdata))
		else $error("read data moved without a read");
	cover property (rd && addr == OFF_INPUT);
	cover property ($rose(irq) && irq_vector[2]);
	cover property (wr && addr == OFF_OUT_HI);
endmodule // pio_checker
bind pio_port pio_checker #(.PULSE_W(PULSE_W)) u_pio_checker (.ref_clk(ref_clk),
	.resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
	.din(din), .dout(dout), .data_accepted(data_accepted), .hi_ready(hi_ready),
	.lo_ready(lo_ready), .irq(irq), .irq_vector(irq_vector));

// File: test/pio_source.sv
// Model of the user equipment that drives the port's input lines.
`timescale 1ns/1ps
module pio_source (
	input wire logic ref_clk, // Clock.
	input wire logic resetn, // Reset.
	input wire logic [15:0] word, // Word to present.
	input wire logic [15:0] wired, // One where a line is cabled.
	output logic [15:0] din // Lines into the port.
);
	logic [15:0] noise_r;
	// Uncabled lines float, so they carry a pattern that flips every cycle.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			noise_r <= 16'h5555;
		end else begin
			noise_r <= ~noise_r;
		end
	end
	// Cabled lines hold the word steady until the next one is placed.
	assign din = (word & wired) | (noise_r & ~wired);
endmodule // pio_source

// File: test/pio_port_tb_top.sv
// Self-checking bench for the parallel word port.
`timescale 1ns/1ps
module pio_port_tb_top;
	import pio_pkg::*;
	localparam int PW = 4;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic [4:0] addr = 5'h00;
	logic [15:0] wdata = 16'h0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [15:0] word = 16'hffff;
	logic [15:0] wired = 16'hffff;
	logic [15:0] rdata, din, dout, w, m;
	logic data_accepted, hi_ready, lo_ready, irq;
	logic [8:0] irq_vector;
	logic [31:0] seed = 32'hdd11_2ff8;
	int errors = 0;
	int compares = 0;
	always #10 ref_clk = ~ref_clk;
	pio_port #(.PULSE_W(PW)) u_pio_port (.ref_clk(ref_clk), .resetn(resetn), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .din(din), .dout(dout),
		.data_accepted(data_accepted), .hi_ready(hi_ready), .lo_ready(lo_ready),
		.irq(irq), .irq_vector(irq_vector));
	pio_source u_pio_source (.ref_clk(ref_clk), .resetn(resetn), .word(word),
		.wired(wired), .din(din));
	// Repeatable random words from a 32-bit xorshift.
	function automatic logic [31:0] xorshift(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		x = x ^ (x << 5);
		return x;
	endfunction
	task automatic rnd(output logic [15:0] r);
		seed = xorshift(seed);
		r = seed[15:0];
	endtask
	// Latched bits 15..12 expected for an edge code and a transition direction.
	function automatic logic [15:0] hit(input logic [1:0] code, input logic rising);
		if (code == EDGE_ANY || code == (rising ? EDGE_RISE : EDGE_FALL)) begin
			return 16'hf000;
		end
		return 16'h0000;
	endfunction
	task automatic idle(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic wreg(input logic [4:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		idle(1);
		wr <= 1'b0;
	endtask
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		compares++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	// The read data stand from the cycle after the strobe until the next read; they are taken in that first cycle.
	task automatic rchk(input string n, input logic [4:0] a, input logic [15:0] e);
		@(posedge ref_clk);
		addr <= a;
		rd <= 1'b1;
		idle(1);
		rd <= 1'b0;
		chk(n, e, rdata);
	endtask
	task automatic stop_test;
		if (errors == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// Main sequence.
	initial begin
		idle(8);
		resetn <= 1'b1;
		rchk("unmapped", 5'h1e, 16'h0000);
		for (int i = 0; i < 8; i++) begin
			rnd(w);
			rnd(m);
			wreg(OFF_CONN, m);
			wired <= m;
			word <= w;
			idle(6);
			rchk("direct", OFF_INPUT, w & m);
		end
		wreg(OFF_CONN, 16'hffff);
		wired <= 16'hffff;
		word <= 16'hffff;
		wreg(OFF_MODE, 16'hffff);
		wreg(OFF_IEN, 16'hffff);
		wreg(OFF_INPUT, 16'hffff);
		wreg(OFF_STATUS, 16'h4000);
		rnd(w);
		word <= w & 16'h7fff;
		idle(6);
		chk("irq vector", 16'h02c0, {6'h00, irq, irq_vector});
		rchk("latched", OFF_INPUT, ~w | 16'h8000);
		chk("accept low", 16'h0000, {15'h0000, data_accepted});
		word <= 16'hffff;
		idle(6);
		rchk("held", OFF_INPUT, ~w | 16'h8000);
		wreg(OFF_INPUT, 16'hffff);
		rchk("cleared", OFF_INPUT, 16'h0000);
		for (int c = 0; c < 3; c++) begin
			wreg(OFF_EDGE, {8'h00, {4{c[1:0]}}});
			word <= 16'h0fff;
			idle(6);
			rchk("fall", OFF_INPUT, hit(c[1:0], 1'b0));
			wreg(OFF_INPUT, 16'hffff);
			word <= 16'hffff;
			idle(6);
			rchk("rise", OFF_INPUT, hit(c[1:0], 1'b1));
			wreg(OFF_INPUT, 16'hffff);
		end
		wreg(OFF_MODE, 16'h0000);
		wreg(OFF_IEN, 16'hf000);
		wreg(OFF_EDGE, {8'h00, {4{EDGE_ANY}}});
		wreg(OFF_INPUT, 16'hffff);
		word <= {4'h7, w[11:0]};
		idle(6);
		chk("change irq", 16'h0001, {15'h0000, irq});
		rchk("change data", OFF_INPUT, {4'h7, w[11:0]});
		wreg(OFF_INPUT, 16'hf000);
		wreg(OFF_STATUS, 16'h0040);
		idle(3);
		chk("change clear", 16'h0000, {15'h0000, irq});
		rchk("pending", OFF_IPEND, {4'h0, ~w[11:0]});
		wreg(OFF_IPEND, 16'hffff);
		rchk("pending cleared", OFF_IPEND, 16'h0000);
		wreg(OFF_OUTPUT, w);
		chk("out word", w, dout);
		chk("ready on", 16'h0000, {14'h0000, hi_ready, lo_ready});
		idle(PW + 3);
		chk("ready off", 16'h0003, {14'h0000, hi_ready, lo_ready});
		chk("out vector", 16'h02c4, {6'h00, irq, irq_vector});
		rnd(m);
		wreg(OFF_VEC, {7'h00, m[5:0], 3'h0});
		idle(1);
		chk("moved vector", {6'h00, 1'b1, m[5:0], 3'h4}, {6'h00, irq, irq_vector});
		rchk("vector reg", OFF_VEC, {7'h00, m[5:0], 3'h0});
		wreg(OFF_STATUS, 16'h0080);
		rnd(m);
		wreg(OFF_OUT_HI, {2{m[7:0]}});
		chk("hi byte", {m[7:0], w[7:0]}, dout);
		chk("hi only", 16'h0001, {14'h0000, hi_ready, lo_ready});
		idle(PW + 3);
		wreg(OFF_OUT_LO, {2{m[15:8]}});
		chk("lo byte", {m[7:0], m[15:8]}, dout);
		wreg(OFF_CTRL, 16'h000f);
		for (int i = 0; i < 4; i++) begin
			rnd(w);
			wreg(OFF_OUTPUT, w);
			idle(PW);
			rchk("loopback", OFF_INPUT, w);
			chk("accept high", 16'h0001, {15'h0000, data_accepted});
		end
		wreg(OFF_STATUS, 16'h0000);
		// Let the interrupt-off check finish before reset disables it.
		idle(3);
		resetn <= 1'b0;
		idle(2);
		chk("reset out", 16'h0000, dout);
		chk("reset irq", 16'h0000, {15'h0000, irq});
		resetn <= 1'b1;
		rchk("reset status", OFF_STATUS, 16'h0000);
		stop_test();
	end
	// The run needs well under a thousand cycles; this cuts a hang short.
	initial begin
		#200000;
		errors++;
		stop_test();
	end
endmodule // pio_port_tb_top
